// File: design/srp_pkg.sv
package srp_pkg;
  // Command opcodes
  localparam logic [7:0] OP_READ_SEC = 8'h48;
  localparam logic [7:0] OP_SET_PROT = 8'h39;
  localparam logic [7:0] OP_READ_STAT3 = 8'h33;
  // Delivered status contents and erased byte
  localparam logic [7:0] STAT_ONE_RST = 8'h00;
  localparam logic [7:0] STAT_TWO_RST = 8'h04;
  localparam logic [7:0] STAT_THREE_RST = 8'h70;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Field positions
  localparam int DIR_BIT = 5;
  localparam int SRP_LO_BIT = 7;
  localparam int SRP_HI_BIT = 0;
  localparam int MODE_BIT = 10;
  localparam int ALL_BIT = 11;
  // Security register selector values (middle address byte)
  localparam logic [7:0] MID_PARAMS = 8'h00;
  localparam logic [7:0] MID_REG1 = 8'h10;
  localparam logic [7:0] MID_REG2 = 8'h20;
  localparam logic [7:0] MID_REG3 = 8'h30;
  // Pointer and sector values
  localparam logic [10:0] PTR_RST = 11'h000;
  localparam logic [3:0] SECT_TOP = 4'hf;
  localparam logic [3:0] SECT_BOT = 4'h0;
  // Last counter values of a transfer
  localparam logic [4:0] OP_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [4:0] DUMMY_LAST = 5'h07;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] BYTE_LAST = 8'hff;
  localparam logic [1:0] STAT3_LAST = 2'h2;
  // Synchroniser reset image {wp_n, si, sck, cs_n}
  localparam logic [3:0] SYNC_RST = 4'h9;

  typedef struct packed {
    logic wp_n;
    logic cs_n;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic si;
  } srp_pins_t;

  typedef struct packed {
    logic block_mode;
    logic all_prot;
    logic [10:0] ptr;
  } srp_prot_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OP, ST_ADDR, ST_DUMMY, ST_SEND, ST_SETP, ST_ARMED, ST_SKIP
  } srp_state_t;
endpackage

// File: design/srp_spi_front.sv
`timescale 1ns/1ps
module srp_spi_front
  import srp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pins from the host
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic wp_n_pin,
  // Cleaned link events
  output srp_pins_t pins
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic sck_prev;
    logic cs_prev;
    srp_pins_t out;
  } srp_front_t;

  srp_front_t q;
  srp_front_t d;

  always_comb
  begin
    d = q;
    d.s1 = {wp_n_pin, si_pin, sck_pin, cs_n_pin};
    d.s2 = q.s1;
    d.sck_prev = q.s2[1];
    d.cs_prev = q.s2[0];
    d.out.wp_n = q.s2[3];
    d.out.si = q.s2[2];
    d.out.cs_n = q.s2[0];
    // Clock edges only count while selected, so mode 3 idle-high is harmless
    d.out.sck_rise = q.s2[1] & ~q.sck_prev & ~q.s2[0];
    d.out.sck_fall = ~q.s2[1] & q.sck_prev & ~q.s2[0];
    d.out.cs_rise = q.s2[0] & ~q.cs_prev;
    d.out.cs_fall = ~q.s2[0] & q.cs_prev;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.s1 <= SYNC_RST;
      q.s2 <= SYNC_RST;
      q.cs_prev <= 1'b1;
      q.out.cs_n <= 1'b1;
      q.out.wp_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign pins = q.out;
endmodule

// File: design/srp_protect.sv
`timescale 1ns/1ps
module srp_protect
  import srp_pkg::*;
(
  // Stored protection choice
  input srp_prot_t cfg,
  input wire logic top_bottom_select,
  input wire logic part_64m,
  input wire logic bp_protected,
  // Query
  input wire logic [22:0] query_addr,
  input wire logic query_block,
  output logic hit
);
  logic [10:0] sect;
  logic [10:0] lo_sect;
  logic [10:0] hi_sect;
  logic [10:0] ptr;

  always_comb
  begin
    sect = {query_addr[22] & part_64m, query_addr[21:12]};
    ptr = {cfg.ptr[10] & part_64m, cfg.ptr[9:0]};
    // A block erase is refused if any sector of its 64 kB block is protected
    lo_sect = query_block ? {sect[10:4], SECT_BOT} : sect;
    hi_sect = query_block ? {sect[10:4], SECT_TOP} : sect;
    if (cfg.block_mode)
    begin
      hit = bp_protected;
    end
    else if (cfg.all_prot)
    begin
      hit = 1'b1;
    end
    else if (!top_bottom_select)
    begin
      hit = hi_sect > ptr;
    end
    else
    begin
      hit = lo_sect < ptr;
    end
  end
endmodule

// File: design/srp_core.sv
// Contract
// - Opcode and address sampled on rising clock
// - Data leaves on falling clock, MSB first
// - Byte address increments, wraps FFh to 00h
// - Middle byte selects one of four registers
// - Nonzero top address byte gives undefined data
// - Security read ignored while busy
// - Address bit 10 picks block or pointer
// - Pointer stored from A22-A12 or A21-A12
// - Bit 11 set protects every sector
// - Direction bit chooses unprotected side
// - Direction zero: pointed sector and below open
// - Direction one: pointed sector and above open
// - Status-protect lock makes 39h ignored
// - Suspend makes 39h ignored
// - 33h returns status three, then pointer bytes
// - Block erase over pointer block is refused; code allows it when none of its sectors is protected
// - Status defaults 00h, 04h, 70h; registers erased
// - Busy reads one during program or erase
`timescale 1ns/1ps
module srp_core
  import srp_pkg::*;
#(
  parameter logic PART_64M = 1'b1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial link pins
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic wp_n_pin,
  output logic so_data,
  output logic so_oe_n,
  // Engine state
  input wire logic cycle_running,
  input wire logic suspend_active,
  input wire logic write_enable_latch,
  // Status register load
  input wire logic sr_wr_en,
  input wire logic [23:0] sr_wr_data,
  // Security register load
  input wire logic sec_wr_en,
  input wire logic [9:0] sec_wr_addr,
  input wire logic [7:0] sec_wr_data,
  // Protection query
  input wire logic bp_protected,
  input wire logic [22:0] query_addr,
  input wire logic query_block,
  output logic query_protected,
  // Status and protection view
  output logic busy,
  output logic [7:0] status_reg_one,
  output logic [7:0] status_reg_two,
  output logic [7:0] status_reg_three,
  output logic prot_block_mode,
  output logic prot_all,
  output logic [10:0] prot_ptr,
  output logic prot_set_done
);
  typedef struct packed {
    srp_state_t st;
    logic [7:0] op;
    logic [23:0] addr;
    logic [4:0] cnt;
    logic [7:0] tx;
    logic [1:0] stat_idx;
    logic so;
    logic so_oe_n;
    srp_prot_t prot;
    logic [23:0] sr;
    logic busy;
    logic qprot;
    logic set_done;
  } srp_core_t;

  srp_core_t q;
  srp_core_t d;
  srp_pins_t pins;
  logic [7:0] sec_mem [0:1023];
  logic [2:0] sel;
  logic [7:0] src;
  logic [7:0] op_next;
  logic locked;
  logic allow;
  logic prot_hit;

  // Maps the top and middle address bytes to {invalid, register index}
  function automatic logic [2:0] reg_select(input logic [23:0] a);
    logic [2:0] r;
    r = 3'h4;
    if (a[23:16] == 8'h00)
    begin
      case (a[15:8])
        MID_PARAMS: r = 3'h0;
        MID_REG1: r = 3'h1;
        MID_REG2: r = 3'h2;
        MID_REG3: r = 3'h3;
        default: r = 3'h4;
      endcase
    end
    return r;
  endfunction

  srp_spi_front u_front (
    .mclk(mclk),
    .rst_n(rst_n),
    .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin),
    .si_pin(si_pin),
    .wp_n_pin(wp_n_pin),
    .pins(pins)
  );

  srp_protect u_protect (
    .cfg(q.prot),
    .top_bottom_select(q.sr[DIR_BIT]),
    .part_64m(PART_64M),
    .bp_protected(bp_protected),
    .query_addr(query_addr),
    .query_block(query_block),
    .hit(prot_hit)
  );

  // Security registers; the parameter area is loaded through the same port
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 1024; i++)
      begin
        sec_mem[i] <= ERASED_BYTE;
      end
    end
    else if (sec_wr_en)
    begin
      sec_mem[sec_wr_addr] <= sec_wr_data;
    end
  end

  always_comb
  begin
    sel = reg_select(q.addr);
    op_next = {q.op[6:0], pins.si};
    // Lock follows the status write protection: hard lock, or soft lock with pin low
    locked = q.sr[8 + SRP_HI_BIT] | (q.sr[SRP_LO_BIT] & ~pins.wp_n);
    allow = write_enable_latch & ~locked & ~suspend_active & ~cycle_running;
    if (q.op == OP_READ_STAT3)
    begin
      case (q.stat_idx)
        2'h0: src = q.sr[23:16];
        2'h1: src = {1'b0, q.prot.ptr[10:4]};
        2'h2: src = {q.prot.ptr[3:0], q.prot.all_prot, q.prot.block_mode, 2'h0};
        default: src = ERASED_BYTE;
      endcase
    end
    else if (sel[2])
    begin
      src = ERASED_BYTE;
    end
    else
    begin
      src = sec_mem[{sel[1:0], q.addr[7:0]}];
    end
  end

  always_comb
  begin
    d = q;
    d.set_done = 1'b0;
    d.busy = cycle_running;
    d.qprot = prot_hit;
    if (sr_wr_en)
    begin
      d.sr = sr_wr_data;
    end
    if (pins.cs_n)
    begin
      d.st = ST_IDLE;
      d.so_oe_n = 1'b1;
      d.so = 1'b0;
      if (q.st == ST_ARMED && allow)
      begin
        d.prot.block_mode = q.addr[MODE_BIT];
        if (!q.addr[MODE_BIT])
        begin
          d.prot.all_prot = q.addr[ALL_BIT];
          d.prot.ptr = {q.addr[22] & PART_64M, q.addr[21:12]};
        end
        d.set_done = 1'b1;
      end
    end
    else if (pins.cs_fall)
    begin
      d.st = ST_OP;
      d.cnt = '0;
      d.op = '0;
      d.addr = '0;
      d.stat_idx = '0;
    end
    else
    begin
      case (q.st)
        ST_OP:
        begin
          if (pins.sck_rise)
          begin
            d.op = op_next;
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == OP_LAST)
            begin
              d.cnt = '0;
              case (op_next)
                OP_READ_SEC: d.st = cycle_running ? ST_SKIP : ST_ADDR;
                OP_SET_PROT: d.st = ST_SETP;
                OP_READ_STAT3: d.st = ST_SEND;
                default: d.st = ST_SKIP;
              endcase
            end
          end
        end
        ST_ADDR, ST_SETP:
        begin
          if (pins.sck_rise)
          begin
            d.addr = {q.addr[22:0], pins.si};
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == ADDR_LAST)
            begin
              d.cnt = '0;
              d.st = (q.st == ST_ADDR) ? ST_DUMMY : ST_ARMED;
            end
          end
        end
        ST_DUMMY:
        begin
          if (pins.sck_rise)
          begin
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == DUMMY_LAST)
            begin
              d.cnt = '0;
              d.st = ST_SEND;
            end
          end
        end
        ST_SEND:
        begin
          if (pins.sck_fall)
          begin
            d.so_oe_n = 1'b0;
            d.cnt = {2'h0, q.cnt[2:0] + 3'h1};
            if (q.cnt[2:0] == 3'h0)
            begin
              d.so = src[7];
              d.tx = {src[6:0], 1'b0};
            end
            else
            begin
              d.so = q.tx[7];
              d.tx = {q.tx[6:0], 1'b0};
            end
            if (q.cnt[2:0] == BIT_LAST)
            begin
              // Only the low byte moves, so the register choice never changes
              d.addr[7:0] = q.addr[7:0] + 8'h01;
              if (q.stat_idx != 2'h3)
              begin
                d.stat_idx = q.stat_idx + 2'h1;
              end
            end
          end
        end
        ST_ARMED:
        begin
          // Extra clocks after the address abandon the command
          if (pins.sck_rise)
          begin
            d.st = ST_SKIP;
          end
        end
        ST_IDLE, ST_SKIP:
        begin
          d.so_oe_n = 1'b1;
        end
        default:
        begin
          d.st = ST_SKIP;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.so_oe_n <= 1'b1;
      q.sr <= {STAT_THREE_RST, STAT_TWO_RST, STAT_ONE_RST};
      q.prot.block_mode <= 1'b1;
      q.prot.ptr <= PTR_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign so_data = q.so;
  assign so_oe_n = q.so_oe_n;
  assign busy = q.busy;
  assign query_protected = q.qprot;
  assign status_reg_one = q.sr[7:0];
  assign status_reg_two = q.sr[15:8];
  assign status_reg_three = q.sr[23:16];
  assign prot_block_mode = q.prot.block_mode;
  assign prot_all = q.prot.all_prot;
  assign prot_ptr = q.prot.ptr;
  assign prot_set_done = q.set_done;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence last_dummy_s;
    q.st == ST_DUMMY && !pins.cs_n && !pins.cs_fall && pins.sck_rise && q.cnt == DUMMY_LAST;
  endsequence

  sequence first_fall_s;
    q.st == ST_SEND && !pins.cs_n && !pins.cs_fall && pins.sck_fall && q.cnt[2:0] == 3'h0;
  endsequence

  opcode_sample_a: assert property (
    (q.st == ST_OP && !pins.cs_n && !pins.cs_fall && pins.sck_rise)
      |=> q.op[0] == $past(pins.si))
    else $error("opcode bit not taken on rising clock");

  dummy_to_send_a: assert property (
    last_dummy_s |=> q.st == ST_SEND && q.so_oe_n)
    else $error("send phase not entered after dummy clocks");

  msb_first_a: assert property (
    first_fall_s |=> q.so == $past(src[7]) && !q.so_oe_n)
    else $error("first data bit is not the byte msb");

  addr_wrap_a: assert property (
    (q.st == ST_SEND && !pins.cs_n && !pins.cs_fall && pins.sck_fall
      && q.cnt[2:0] == BIT_LAST && q.addr[7:0] == BYTE_LAST)
      |=> q.addr[7:0] == 8'h00 && $stable(q.addr[15:8]))
    else $error("byte address did not wrap within register");

  top_byte_a: assert property (
    (q.addr[23:16] != 8'h00 && q.op == OP_READ_SEC) |-> src == ERASED_BYTE)
    else $error("nonzero top byte returned register data");

  busy_ignore_a: assert property (
    (q.st == ST_OP && !pins.cs_n && !pins.cs_fall && pins.sck_rise
      && q.cnt == OP_LAST && op_next == OP_READ_SEC && cycle_running)
      |=> q.st == ST_SKIP)
    else $error("security read accepted while busy");

  lock_ignore_a: assert property (
    (locked || suspend_active) |-> !allow)
    else $error("protection select allowed while locked");

  prot_keep_a: assert property (
    (pins.cs_n && !allow) |=> $stable(q.prot) && !q.set_done)
    else $error("ignored protection select changed state");

  release_a: assert property (
    pins.cs_n |=> q.so_oe_n ##1 q.so_oe_n)
    else $error("output still driven after deselect");

  all_protect_a: assert property (
    (!q.prot.block_mode && q.prot.all_prot) |=> q.qprot)
    else $error("all-protect did not protect the query");

  busy_flag_a: assert property (
    $rose(cycle_running) |=> busy ##1 (busy || !$past(cycle_running)))
    else $error("busy flag did not follow cycle state");
endmodule

// File: verification/srp_host_model.sv
`timescale 1ns/1ps
module srp_host_model
  import srp_pkg::*;
(
  // Bench clock
  input wire logic mclk,
  // Link to the device
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  logic [7:0] rx[$];
  logic drove;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    drove = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Mode 0; unused si toggles so a stale bit cannot pass for a driven one
  task automatic xfer(input logic [31:0] hdr, input int nbits, input int ndum, input int nrd);
    logic [7:0] b;
    int pre;
    b = 8'h00;
    pre = 4;
    rx.delete();
    drove = 1'b0;
    cs_n = 1'b0;
    for (int i = 0; i < nbits + ndum + 8 * nrd; i++)
    begin
      wait_n(pre);
      sck = 1'b0;
      si = (i < nbits) ? hdr[31 - i] : ~si;
      wait_n(4);
      sck = 1'b1;
      pre = 4;
      if (i >= nbits + ndum)
      begin
        // Sample late in the high phase, data follows the fall by a few cycles
        wait_n(3);
        // An undriven line reads back inverted, so a missing enable shows up
        b = {b[6:0], so_oe_n ? ~so : so};
        drove = drove | ~so_oe_n;
        pre = 1;
        if ((i - nbits - ndum) % 8 == 7)
          rx.push_back(b);
      end
    end
    wait_n(pre);
    sck = 1'b0;
    wait_n(4);
    cs_n = 1'b1;
    si = ~si;
    wait_n(4);
  endtask
endmodule

// File: verification/srp_core_tb.sv
`timescale 1ns/1ps
module srp_core_tb
  import srp_pkg::*;
();
  logic mclk = 1'b0;
  logic rst_n, cs_n, sck, si, so, so_oe_n, wp_n, cyc, susp, wen, sr_en, sec_en, bp, qb, qp;
  logic busy, pbm, pall, pdone;
  logic [23:0] sr_data, a;
  logic [9:0] sec_addr;
  logic [7:0] sec_data, s1, s2, s3;
  logic [22:0] qa;
  logic [10:0] pptr;
  logic [31:0] rnd = 32'h1ba216a3;
  logic [23:0] tab[6] = '{24'h0000fe, 24'h0010fe, 24'h0020fe, 24'h0030fe, 24'h0040fe,
    24'h0110fe};
  int err_total = 0;
  int samples_checked = 0;
  int done_cnt = 0;
  int mem[1024];
  int m_stat1, m_ptr;
  bit m_blk, m_all;

  always #5 mclk = ~mclk;
  always @(posedge mclk)
    if (pdone === 1'b1)
      done_cnt++;

  srp_core #(.PART_64M(1'b1)) srp_core_i (
    .mclk(mclk), .rst_n(rst_n), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
    .wp_n_pin(wp_n), .so_data(so), .so_oe_n(so_oe_n), .cycle_running(cyc),
    .suspend_active(susp), .write_enable_latch(wen), .sr_wr_en(sr_en),
    .sr_wr_data(sr_data), .sec_wr_en(sec_en), .sec_wr_addr(sec_addr),
    .sec_wr_data(sec_data), .bp_protected(bp), .query_addr(qa), .query_block(qb),
    .query_protected(qp), .busy(busy), .status_reg_one(s1), .status_reg_two(s2),
    .status_reg_three(s3), .prot_block_mode(pbm), .prot_all(pall), .prot_ptr(pptr),
    .prot_set_done(pdone));
  srp_host_model srp_host_model_i (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
    .so_oe_n(so_oe_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic sr_load(input logic [7:0] v1, input logic [7:0] v2);
    sr_en = 1'b1;
    sr_data = {STAT_THREE_RST, v2, v1};
    m_stat1 = v1;
    step(1);
    sr_en = 1'b0;
    chk("status_load", {v2, v1}, {s2, s1});
  endtask
  task automatic set_prot(input logic [23:0] ad, input bit ok);
    int d;
    d = done_cnt;
    srp_host_model_i.xfer({OP_SET_PROT, ad}, 32, 0, 0);
    step(4);
    chk("set_done", ok, done_cnt - d);
    if (ok)
    begin
      m_blk = ad[MODE_BIT];
      if (!ad[MODE_BIT])
      begin
        m_all = ad[ALL_BIT];
        m_ptr = ad[22:12];
      end
    end
    chk("block_mode", m_blk, pbm);
    chk("all_prot", m_all, pall);
    chk("pointer", m_ptr, pptr);
  endtask
  task automatic query(input int ad, input bit blk);
    int s;
    bit p;
    ad = ad & 32'h7fffff;
    qa = ad[22:0];
    qb = blk;
    p = 1'b0;
    if (m_blk)
      p = bp;
    else if (m_all)
      p = 1'b1;
    else
      for (int i = 0; i < (blk ? 16 : 1); i++)
      begin
        s = blk ? (ad >> 16) * 16 + i : ad >> 12;
        p = p | (m_stat1[DIR_BIT] ? s < m_ptr : s > m_ptr);
      end
    step(2);
    chk("query", p, qp);
  endtask
  task automatic rd_sec(input logic [23:0] ad);
    int e;
    srp_host_model_i.xfer({OP_READ_SEC, ad}, 32, 8, 5);
    for (int k = 0; k < 5; k++)
    begin
      e = (ad[23:16] == 0 && ad[11:8] == 0 && ad[15:14] == 0) ?
        mem[ad[13:12] * 256 + (ad[7:0] + k) % 256] : 255;
      chk("sec_byte", e, srp_host_model_i.rx[k]);
    end
    step(4);
    chk("so_release", 1, so_oe_n);
  endtask
  task automatic tend(input string n);
    $display("test %s finished", n);
  endtask

  initial
  begin
    rst_n = 1'b0;
    {wp_n, cyc, susp, wen, sr_en, sec_en, bp, qb} = 8'h80;
    {sr_data, sec_addr, sec_data, qa} = '0;
    {m_stat1, m_ptr, m_blk, m_all} = {32'd0, 32'd0, 2'b10};
    for (int i = 0; i < 1024; i++)
      mem[i] = 255;
    step(5);
    rst_n = 1'b1;
    step(1);
    chk("status_rst", {STAT_THREE_RST, STAT_TWO_RST, STAT_ONE_RST}, {s3, s2, s1});
    chk("prot_rst", 13'h1000, {pbm, pall, pptr});
    chk("idle", 2'b01, {busy, so_oe_n});
    tend("reset");
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      sec_en = 1'b1;
      sec_addr = {i[3:2], 8'hfe + i[1:0]};
      sec_data = rnd[7:0];
      mem[sec_addr] = rnd[7:0];
      step(1);
    end
    sec_en = 1'b0;
    foreach (tab[i])
      rd_sec(tab[i]);
    tend("secreg");
    cyc = 1'b1;
    step(2);
    chk("busy", 1, busy);
    srp_host_model_i.xfer({OP_READ_SEC, tab[1]}, 32, 8, 1);
    chk("drove", 0, srp_host_model_i.drove);
    cyc = 1'b0;
    step(2);
    chk("busy", 0, busy);
    tend("busy");
    wen = 1'b1;
    for (int t = 0; t < 6; t++)
    begin
      rnd = lfsr(rnd);
      sr_load({2'b00, t[0], 5'h00}, STAT_TWO_RST);
      a = {rnd[31], rnd[10:4], (t < 2) ? rnd[3:0] : (t < 4) ? 4'hf : 4'h0, 2'b00, rnd[19:10]};
      set_prot(a, 1'b1);
      srp_host_model_i.xfer({OP_READ_STAT3, 24'h000000}, 8, 0, 4);
      chk("stat3_read", {STAT_THREE_RST, 1'b0, a[22:16], a[15:12], 4'h0, 8'hff},
        {srp_host_model_i.rx[0], srp_host_model_i.rx[1], srp_host_model_i.rx[2],
        srp_host_model_i.rx[3]});
      query(a, 1'b0);
      query(a + 24'h001000, 1'b0);
      query(a - 24'h001000, 1'b0);
      query(a, 1'b1);
    end
    tend("pointer");
    for (int c = 0; c < 5; c++)
    begin
      rnd = lfsr(rnd);
      wen = c != 0;
      susp = c == 2;
      wp_n = c != 3;
      sr_load((c >= 3) ? 8'h80 : 8'h00, (c == 1) ? 8'h05 : 8'h04);
      set_prot({1'b0, rnd[10:0], 12'h000}, c == 4);
    end
    {wen, susp, wp_n} = 3'b101;
    sr_load(STAT_ONE_RST, STAT_TWO_RST);
    tend("refuse");
    set_prot({1'b0, m_ptr[10:0], 2'b10, 10'h000}, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4)
        set_prot(24'h000400, 1'b1);
      rnd = lfsr(rnd);
      bp = rnd[0];
      query(rnd, rnd[31]);
    end
    tend("modes");
    summarize();
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    err_total++;
    summarize();
  end
endmodule
